/* File: bench/psier_props.sv */
// assertion checker for the link status and event enable register bank
`timescale 1ns/1ps
module psier_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [1:0]  resolved_rate_field,
  input wire logic        full_duplex,
  input wire logic        neg_enabled,
  input wire logic        neg_complete,
  input wire logic        link_up,
  input wire logic        downshift_active_flag,
  input wire logic        sleep_active,
  input wire logic [3:0]  channel_polarity_reversed,
  input wire logic        jabber_seen,
  input wire logic        irq
);
  logic        rd_st_q;
  logic        rd_en_q;
  logic        wr_en_q;
  logic [15:0] en_q;
  logic [12:0] st_prev;
  logic [2:0]  calm_q;
  wire         take = hsel && htrans[1] && hreadyout;
  wire  [12:0] st_vec = {resolved_rate_field, full_duplex, neg_enabled, neg_complete, link_up,
                         downshift_active_flag, sleep_active, jabber_seen,
                         channel_polarity_reversed};
  // status checks only once inputs sat still long enough to pass the synchroniser
  wire         calm = calm_q >= 3'h5 && st_vec == st_prev;
  wire         chk = rd_st_q && calm;
  wire         en_any = |en_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_st_q <= 1'b0;
      rd_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      en_q    <= 16'h0000;
      st_prev <= 13'h0000;
      calm_q  <= 3'h0;
    end else begin
      rd_st_q <= take && !hwrite && haddr[31:2] == psier_pkg::IDX_STATUS;
      rd_en_q <= take && !hwrite && haddr[31:2] == psier_pkg::IDX_IRQ_EN;
      wr_en_q <= take && hwrite && haddr[31:2] == psier_pkg::IDX_IRQ_EN;
      if (wr_en_q) begin
        en_q <= hwdata[15:0] & psier_pkg::EV_MASK;
      end
      st_prev <= st_vec;
      calm_q  <= (st_vec != st_prev) ? 3'h0 : ((calm_q == 3'h7) ? calm_q : calm_q + 3'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  rdata_high_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper read data set");
  rate_code_a: assert property (chk |-> hrdata[15:14] ==
    ((resolved_rate_field == 2'h3) ? 2'h0 : resolved_rate_field)) else $error("speed field");
  rsvd_rate_a: assert property (rd_st_q |-> hrdata[15:14] != 2'h3)
    else $error("reserved speed shown");
  duplex_bit_a: assert property (chk |-> hrdata[13] == full_duplex) else $error("duplex");
  neg_resolved_a: assert property (chk |-> hrdata[11] == (!neg_enabled || neg_complete))
    else $error("resolution bit");
  link_live_a: assert property (chk |-> hrdata[10] == link_up) else $error("link bit");
  downshift_bit_a: assert property (chk |-> hrdata[7] ==
    (downshift_active_flag && neg_enabled && !neg_complete)) else $error("downshift bit");
  sleep_bit_a: assert property (chk |-> hrdata[6] == sleep_active) else $error("sleep bit");
  polarity_gate_a: assert property (chk |-> hrdata[5:2] ==
    ((link_up && resolved_rate_field == 2'h2) ? channel_polarity_reversed : 4'h0))
    else $error("polarity field");
  jabber_bit_a: assert property (chk |-> hrdata[0] == jabber_seen) else $error("jabber");
  en_reserved_a: assert property (rd_en_q |-> (hrdata[15:0] & ~psier_pkg::EV_MASK) == 16'h0)
    else $error("reserved enable bit set");
  en_readback_a: assert property (rd_en_q |-> hrdata[15:0] == en_q)
    else $error("enable readback");
  irq_gated_a: assert property (irq |-> $past(en_any)) else $error("irq with no enable");
  status_read_c: cover property (chk);
  irq_rise_c: cover property ($rose(irq));
  en_write_c: cover property (wr_en_q);
endmodule // psier_props

bind psier_top psier_props psier_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hreadyout, .hrdata, .hresp, .resolved_rate_field, .full_duplex, .neg_enabled,
  .neg_complete, .link_up, .downshift_active_flag, .sleep_active, .channel_polarity_reversed,
  .jabber_seen, .irq);

/* File: bench/tb_psier_top.sv */
// self-checking bench for the link status and event enable register bank
`timescale 1ns/1ps
module tb_psier_top;
  localparam logic [31:0] A_ST = {psier_pkg::IDX_STATUS, 2'b00};
  localparam logic [31:0] A_EN = {psier_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [31:0] A_EV = {psier_pkg::IDX_IRQ_STAT, 2'b00};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [1:0]  rate = 2'h0;
  logic [9:0]  lv = 10'h002; // duplex nen ncomp link cd ab ds sleep rxpol jabber
  logic [3:0]  pol = 4'h0;
  logic [3:0]  ev = 4'h0;    // neg error, page, false carrier, wake
  logic [15:0] tbl [6] = '{16'hA62A, 16'hD5D5, 16'h78BF, 16'h0733, 16'h908C, 16'h8C66};
  int          evb [4] = '{3, 8, 12, 15};
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;

  psier_top psier_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .resolved_rate_field(rate),
    .full_duplex(lv[9]), .neg_enabled(lv[8]), .neg_complete(lv[7]), .link_up(lv[6]),
    .crossover_pairs_cd(lv[5]), .crossover_pairs_ab(lv[4]), .downshift_active_flag(lv[3]),
    .sleep_active(lv[2]), .channel_polarity_reversed(pol), .rx_polarity_ok(lv[1]),
    .jabber_seen(lv[0]), .neg_error_seen(ev[3]), .page_seen(ev[2]),
    .false_carrier_seen(ev[1]), .wake_packet_seen(ev[0]), .irq(irq));

  always #2.5 hclk = ~hclk;

  task automatic test_done();
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the whole run needs under three hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; waits on hready, never assumes a latency
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // inputs pass a two-stage synchroniser before they show
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    repeat (3) @(posedge hclk);
    ev[k] <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  function automatic logic [31:0] est();
    logic [15:0] s;
    s[15:14] = (rate == 2'h3) ? 2'h0 : rate;
    s[13:8]  = {lv[9], 1'b0, ~lv[8] | lv[7], lv[6:4]};
    s[7]     = lv[3] & lv[8] & ~lv[7];
    s[6]     = lv[2];
    s[5:2]   = (lv[6] && rate == 2'h2) ? pol : 4'h0;
    s[1:0]   = lv[1:0];
    return {16'h0000, s};
  endfunction

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(A_ST, 32'h0000_0802);
    rdchk(A_EN, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      {rate, lv, pol} <= tbl[i];
      settle();
      rdchk(A_ST, est());
      rdchk(A_ST, est());
    end
    pulse(2);
    rdchk(A_ST, est() | 32'h0000_1000);
    rdchk(A_ST, est());
    for (int b = 0; b < 16; b++) begin
      bus(1'b1, A_EN, 32'hFFFF_0000 | (32'h1 << b));
      rdchk(A_EN, (32'h1 << b) & 32'h0000_FD78);
    end
    bus(1'b1, A_EN, 32'h0000_0000);
    bus(1'b0, A_EV, 32'h0);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      chk({31'h0, irq}, 32'h0);
      rdchk(A_EV, 32'h1 << evb[k]);
      rdchk(A_EV, 32'h0);
    end
    bus(1'b1, A_EN, 32'h0000_0008);
    lv[6] <= ~lv[6];
    settle();
    chk({31'h0, irq}, 32'h0);
    rdchk(A_EV, 32'h0000_0400);
    // speed, duplex, crossover, downshift rise and sleep change in one go
    rate <= rate ^ 2'h1;
    lv   <= lv ^ 10'h22C;
    settle();
    chk({31'h0, irq}, 32'h0);
    rdchk(A_EV, 32'h0000_6070);
    bus(1'b1, A_EN, 32'h0000_FFFF);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, A_EV, 32'h0);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
    end
    rdchk(32'h0000_0040, 32'h0);
    bus(1'b1, A_ST, 32'h0000_FFFF);
    rdchk(A_ST, est() | 32'h0000_1000);
    rdchk(A_EN, 32'h0000_FD78);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(A_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule // tb_psier_top

/* File: hdl/psier_flag_if.sv */
// sticky flag group carried between the bank and its flag keeper
`timescale 1ns/1ps
interface psier_flag_if #(
  parameter int W = 1
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flag;
  modport keeper (input set, input clr, output flag);
  modport user   (output set, output clr, input flag);
endinterface

/* File: hdl/psier_pkg.sv */
// constants for the link status and event enable register bank
package psier_pkg;

  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_STATUS   = 30'h0000_0011;
  localparam logic [29:0] IDX_IRQ_EN   = 30'h0000_0012;
  localparam logic [29:0] IDX_IRQ_STAT = 30'h0000_0013;

  // phy_link_status field positions
  localparam int RATE_HI      = 15;
  localparam int RATE_LO      = 14;
  localparam int DUPLEX_BIT   = 13;
  localparam int PAGE_BIT     = 12;
  localparam int RESOLVED_BIT = 11;
  localparam int LINK_BIT     = 10;
  localparam int XOVER_CD_BIT = 9;
  localparam int XOVER_AB_BIT = 8;
  localparam int DOWNSHIFT_BIT = 7;
  localparam int SLEEP_BIT    = 6;
  localparam int POL_HI       = 5;
  localparam int POL_LO       = 2;
  localparam int RXPOL_BIT    = 1;
  localparam int JABBER_BIT   = 0;

  // event positions, shared by the enable and the event status registers
  localparam int EV_NEG_ERR   = 15;
  localparam int EV_RATE      = 14;
  localparam int EV_DUPLEX    = 13;
  localparam int EV_PAGE      = 12;
  localparam int EV_NEG_DONE  = 11;
  localparam int EV_LINK      = 10;
  localparam int EV_FALSE_CAR = 8;
  localparam int EV_XOVER     = 6;
  localparam int EV_DOWNSHIFT = 5;
  localparam int EV_SLEEP     = 4;
  localparam int EV_WAKE      = 3;

  // writable enable bits; 9, 7 and 2:0 read zero here
  localparam logic [15:0] EV_MASK    = 16'hFD78;
  localparam logic [15:0] EN_RST     = 16'h0000;
  localparam logic [15:0] EV_STAT_RST = 16'h0000;

  // speed codes
  localparam logic [1:0] RATE_10    = 2'h0;
  localparam logic [1:0] RATE_1000  = 2'h2;
  localparam logic [1:0] RATE_RSVD  = 2'h3;

  // synchronised input vector layout
  localparam int SYNC_W = 22;
  localparam logic [21:0] SYNC_RST = 22'h00_4000;

  typedef enum logic [1:0] {
    PSIER_IDLE  = 2'h1,
    PSIER_WRITE = 2'h2
  } psier_phase_e;

endpackage

/* File: hdl/psier_sticky.sv */
// set-wins sticky flags, cleared by a one-cycle clear
`timescale 1ns/1ps
module psier_sticky #(
  parameter int W = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  psier_flag_if.keeper f
);
  logic [W-1:0] flag_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~f.clr) | f.set;
    end
  end

  assign f.flag = flag_r;
endmodule // psier_sticky

/* File: hdl/psier_sync.sv */
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module psier_sync #(
  parameter int          W   = 1,
  parameter logic [21:0] RST = 22'h00_0000
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // meta_r feeds only q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST[W-1:0];
      q      <= RST[W-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // psier_sync

/* File: hdl/psier_top.sv */
// link status and event enable register bank on an ahb-lite slave
//
// Function
// R01: status bits 15:14 report speed: 10 gigabit, 01 hundred, 00 ten
// R02: status bit 13 reads one for full duplex, zero for half
// R03: status bit 12 latches page arrival, cleared by reading the status word
// R04: status bit 11 is one when negotiation is done or disabled
// R05: status bit 10 follows the live link state without latching
// R06: bits 9 and 8 give crossover of pairs cd and ab, one is mdix
// R07: bit 7 is one only while negotiating with gigabit abilities hidden
// R08: bit 6 reads one while the device sleeps
// R09: bits 5:2 give channel d,c,b,a polarity reversal at gigabit link
// R10: bit 1 gives ten-megabit receive polarity, one correct, resets to one
// R11: bit 0 mirrors jabber and is never cleared by reading
// R12: an event raises the interrupt only when enabled; enables reset zero
// R13: enable bits 15, 14, 13: negotiation error, speed, duplex change
// R14: enable bits 12, 11, 10: page, negotiation done, link change
// R15: enable bits 8, 6, 5, 4, 3; bits 9 and 7 read zero
// R16: event flags set whether or not enabled
// R17: event flags hold events since last read; that read clears them
// R18: speed code 11 is never reported
`timescale 1ns/1ps
module psier_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [1:0]  resolved_rate_field,
  input  wire logic        full_duplex,
  input  wire logic        neg_enabled,
  input  wire logic        neg_complete,
  input  wire logic        link_up,
  input  wire logic        crossover_pairs_cd,
  input  wire logic        crossover_pairs_ab,
  input  wire logic        downshift_active_flag,
  input  wire logic        sleep_active,
  input  wire logic [3:0]  channel_polarity_reversed,
  input  wire logic        rx_polarity_ok,
  input  wire logic        jabber_seen,
  input  wire logic        neg_error_seen,
  input  wire logic        page_seen,
  input  wire logic        false_carrier_seen,
  input  wire logic        wake_packet_seen,
  output logic             irq
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [psier_pkg::SYNC_W-1:0] raw_in;
  logic [psier_pkg::SYNC_W-1:0] s;
  logic [psier_pkg::SYNC_W-1:0] s_prev_r;

  assign raw_in = {2'b00,
                   wake_packet_seen,
                   false_carrier_seen,
                   page_seen,
                   neg_error_seen,
                   jabber_seen,
                   rx_polarity_ok,
                   channel_polarity_reversed,
                   sleep_active,
                   downshift_active_flag,
                   crossover_pairs_ab,
                   crossover_pairs_cd,
                   link_up,
                   neg_complete,
                   neg_enabled,
                   full_duplex,
                   resolved_rate_field};

  // all status comes from the phy core domains, so everything is resynced
  psier_sync #(
    .W   (psier_pkg::SYNC_W),
    .RST (psier_pkg::SYNC_RST)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (raw_in),
    .q     (s)
  );

  // previous sample, for change and edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_prev_r <= psier_pkg::SYNC_RST;
    end else begin
      s_prev_r <= s;
    end
  end

  // ---------------------------------------------------------------
  // decoded status fields
  // ---------------------------------------------------------------
  logic [1:0] rate_raw;
  logic [1:0] rate_prev;
  logic [1:0] rate_rep;
  logic       duplex_s;
  logic       neg_en_s;
  logic       neg_done_s;
  logic       link_s;
  logic       xcd_s;
  logic       xab_s;
  logic       dshift_s;
  logic       sleep_s;
  logic [3:0] pol_s;
  logic       rxpol_s;
  logic       jab_s;
  logic       err_s;
  logic       page_s;
  logic       fcar_s;
  logic       wake_s;

  assign rate_raw   = s[1:0];
  assign rate_prev  = s_prev_r[1:0];
  assign duplex_s   = s[2];
  assign neg_en_s   = s[3];
  assign neg_done_s = s[4];
  assign link_s     = s[5];
  assign xcd_s      = s[6];
  assign xab_s      = s[7];
  assign dshift_s   = s[8];
  assign sleep_s    = s[9];
  assign pol_s      = s[13:10];
  assign rxpol_s    = s[14];
  assign jab_s      = s[15];
  assign err_s      = s[16];
  assign page_s     = s[17];
  assign fcar_s     = s[18];
  assign wake_s     = s[19];

  // a reserved code from the core is reported as ten megabit
  assign rate_rep = (rate_raw == psier_pkg::RATE_RSVD) ? psier_pkg::RATE_10 : rate_raw; // R18

  logic resolved;
  logic dshift_show;
  logic [3:0] pol_show;

  assign resolved    = ~neg_en_s | neg_done_s; // R04
  // only meaningful while negotiation is still running
  assign dshift_show = dshift_s & neg_en_s & ~neg_done_s; // R07
  assign pol_show    = (link_s && rate_rep == psier_pkg::RATE_1000) ? pol_s : 4'h0; // R09

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  logic [15:0] ev;

  always_comb begin
    ev = 16'h0000;
    ev[psier_pkg::EV_NEG_ERR]   = err_s & ~s_prev_r[16];
    ev[psier_pkg::EV_RATE]      = rate_raw != rate_prev;
    ev[psier_pkg::EV_DUPLEX]    = duplex_s != s_prev_r[2];
    ev[psier_pkg::EV_PAGE]      = page_s & ~s_prev_r[17];
    ev[psier_pkg::EV_NEG_DONE]  = neg_done_s & ~s_prev_r[4];
    ev[psier_pkg::EV_LINK]      = link_s != s_prev_r[5];
    ev[psier_pkg::EV_FALSE_CAR] = fcar_s & ~s_prev_r[18];
    ev[psier_pkg::EV_XOVER]     = (xcd_s != s_prev_r[6]) | (xab_s != s_prev_r[7]);
    ev[psier_pkg::EV_DOWNSHIFT] = dshift_s & ~s_prev_r[8];
    ev[psier_pkg::EV_SLEEP]     = sleep_s != s_prev_r[9];
    ev[psier_pkg::EV_WAKE]      = wake_s & ~s_prev_r[19];
  end

  // ---------------------------------------------------------------
  // ahb-lite address phase
  // ---------------------------------------------------------------
  logic        take;
  logic        rd_take;
  logic        wr_take;
  logic [29:0] word_idx;
  logic        hit_status;
  logic        hit_en;
  logic        hit_stat;

  assign take     = hsel & hready & htrans[1];
  assign rd_take  = take & ~hwrite;
  assign wr_take  = take & hwrite;
  assign word_idx = haddr[31:2];

  assign hit_status = word_idx == psier_pkg::IDX_STATUS;
  assign hit_en     = word_idx == psier_pkg::IDX_IRQ_EN;
  assign hit_stat   = word_idx == psier_pkg::IDX_IRQ_STAT;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // write data phase tracking
  // ---------------------------------------------------------------
  // the data phase edge commits a write; the address phase only arms it
  psier_pkg::psier_phase_e phase_r;
  logic                    wr_en_pend_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= psier_pkg::PSIER_IDLE;
    end else begin
      case (phase_r)
        psier_pkg::PSIER_IDLE: begin
          if (wr_take) begin
            phase_r <= psier_pkg::PSIER_WRITE;
          end
        end
        psier_pkg::PSIER_WRITE: begin
          if (!wr_take) begin
            phase_r <= psier_pkg::PSIER_IDLE;
          end
        end
        default: begin
          phase_r <= psier_pkg::PSIER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_pend_r <= 1'b0;
    end else begin
      wr_en_pend_r <= wr_take & hit_en;
    end
  end

  logic wr_en_now;

  assign wr_en_now = (phase_r == psier_pkg::PSIER_WRITE) & wr_en_pend_r;

  // ---------------------------------------------------------------
  // event enable register
  // ---------------------------------------------------------------
  logic [15:0] irq_en_r;
  logic [15:0] irq_en_nxt;

  // reserved and unimplemented bits stay zero
  assign irq_en_nxt = hwdata[15:0] & psier_pkg::EV_MASK; // R13 R14 R15

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= psier_pkg::EN_RST; // R12
    end else if (wr_en_now) begin
      irq_en_r <= irq_en_nxt; // R13 R14 R15
    end
  end

  // ---------------------------------------------------------------
  // sticky flags: page bit of the status word and the event word
  // ---------------------------------------------------------------
  psier_flag_if #(.W(1))  page_if ();
  psier_flag_if #(.W(16)) evt_if ();

  assign page_if.set = ev[psier_pkg::EV_PAGE]; // R03
  assign page_if.clr = rd_take & hit_status; // R03
  assign evt_if.set  = ev & psier_pkg::EV_MASK; // R16
  assign evt_if.clr  = (rd_take & hit_stat) ? 16'hFFFF : 16'h0000; // R17

  psier_sticky #(.W(1)) u_page (
    .clk   (hclk),
    .rst_n (hresetn),
    .f     (page_if.keeper)
  );

  psier_sticky #(.W(16)) u_evt (
    .clk   (hclk),
    .rst_n (hresetn),
    .f     (evt_if.keeper)
  );

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  logic [15:0] st_word;

  always_comb begin
    st_word = 16'h0000;
    st_word[psier_pkg::RATE_HI:psier_pkg::RATE_LO] = rate_rep; // R01
    st_word[psier_pkg::DUPLEX_BIT]    = duplex_s; // R02
    st_word[psier_pkg::PAGE_BIT]      = page_if.flag; // R03
    st_word[psier_pkg::RESOLVED_BIT]  = resolved; // R04
    st_word[psier_pkg::LINK_BIT]      = link_s; // R05
    st_word[psier_pkg::XOVER_CD_BIT]  = xcd_s; // R06
    st_word[psier_pkg::XOVER_AB_BIT]  = xab_s; // R06
    st_word[psier_pkg::DOWNSHIFT_BIT] = dshift_show; // R07
    st_word[psier_pkg::SLEEP_BIT]     = sleep_s; // R08
    st_word[psier_pkg::POL_HI:psier_pkg::POL_LO] = pol_show; // R09
    st_word[psier_pkg::RXPOL_BIT]     = rxpol_s; // R10
    st_word[psier_pkg::JABBER_BIT]    = jab_s; // R11
  end

  // ---------------------------------------------------------------
  // read data, registered at the address phase edge
  // ---------------------------------------------------------------
  logic [15:0] en_view;
  logic [15:0] rd_word;

  // a read right behind a write to the enables sees the new value
  assign en_view = wr_en_now ? irq_en_nxt : irq_en_r;

  always_comb begin
    rd_word = 16'h0000;
    if (hit_status) begin
      rd_word = st_word;
    end else if (hit_en) begin
      rd_word = en_view;
    end else if (hit_stat) begin
      rd_word = evt_if.flag;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= {16'h0000, rd_word};
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_if.flag & irq_en_r); // R12
    end
  end

  // unused bus inputs: only whole-word transfers are expected
  logic unused_ok;

  assign unused_ok = &{1'b0, hsize, htrans[0], hwdata[31:16], s[21:20]};

endmodule // psier_top
